// ### mpx_bus_model.sv
// Purpose: behavioural bus interface answering io and memory requests of mpx_exec
// Assumes: one request at a time; done pulses are one cycle wide
// Notes: answers after 0, 1 or 2 idle cycles in turn; memory writes are logged
`timescale 1ns/10ps
module mpx_bus_model (
  input wire logic aclk,
  input wire logic io_req,
  input wire logic [15:0] io_port,
  input wire logic io_word,
  output logic io_done,
  output logic [15:0] io_rdata,
  input wire logic mem_req,
  input wire logic [15:0] mem_seg,
  input wire logic [15:0] mem_off,
  input wire logic mem_word,
  input wire logic [15:0] mem_wdata,
  input wire logic aresetn,
  output logic mem_done
);
  int io_cnt = 0;
  int mem_cnt = 0;
  int gap = 0;
  logic [15:0] last_port = 16'h0000;
  logic last_word = 1'b0;
  logic [15:0] log_off [0:15];
  logic [15:0] log_seg [0:15];
  logic [15:0] log_data [0:15];
  initial io_done = 1'b0;
  initial mem_done = 1'b0;
  initial io_rdata = 16'h0000;
  // read data is only valid in the done cycle, so it is inverted at every edge that gives no io done
  always @(posedge aclk)
  begin
    io_done <= 1'b0;
    mem_done <= 1'b0;
    io_rdata <= ~io_rdata;
    if (aresetn && io_req && !io_done)
    begin
      gap <= gap + 1;
      if (gap >= io_cnt % 3)
      begin
        io_done <= 1'b1;
        io_rdata <= io_port ^ 16'hc3a5;
        last_port <= io_port;
        last_word <= io_word;
        io_cnt <= io_cnt + 1;
        gap <= 0;
      end
    end
    else if (aresetn && mem_req && !mem_done)
    begin
      gap <= gap + 1;
      if (gap >= mem_cnt % 3)
      begin
        mem_done <= 1'b1;
        log_off[mem_cnt % 16] <= mem_off;
        log_seg[mem_cnt % 16] <= mem_seg;
        log_data[mem_cnt % 16] <= mem_word ? mem_wdata : {8'h00, mem_wdata[7:0]};
        mem_cnt <= mem_cnt + 1;
        gap <= 0;
      end
    end
  end
endmodule

// ### mpx_exec.sv
// Purpose: execution unit slice for signed multiply, port input, increment, block port input
// Assumes: bus interface answers io and memory requests with a one-cycle done pulse
// Notes: operands and results are held in registers reached over AXI4-Lite
`timescale 1ns/10ps
// Summary of operation
// (RQ1) byte multiply: source times low accumulator byte, 16-bit product into accumulator
// (RQ2) word multiply: source times accumulator, product high to port reg, low to accumulator
// (RQ3) multiply sets carry and overflow when upper half is not sign extension
// (RQ4) multiply leaves aux, parity, sign, zero undefined; direction, interrupt, trap kept
// (RQ5) port input loads low byte or whole accumulator word by operand size
// (RQ6) immediate port number reaches only ports 0 through 255
// (RQ7) register-held port number reaches any port 0 through 65535
// (RQ8) port input changes no flag
// (RQ9) increment adds one; updates aux, overflow, parity, sign, zero; keeps carry
// (RQ10) block input reads port from port reg, writes extra segment at dest pointer
// (RQ11) dest pointer steps 1 or 2, up if direction clear, down if set
// (RQ12) repeated block input does successive transfers, stepping per element
// (RQ13) repeated form decrements count each element, stops at zero, none if zero
module mpx_exec (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic io_req,
  output logic [15:0] io_port,
  output logic io_word,
  input wire logic io_done,
  input wire logic [15:0] io_rdata,
  output logic mem_req,
  output logic [15:0] mem_seg,
  output logic [15:0] mem_off,
  output logic mem_word,
  output logic [15:0] mem_wdata,
  input wire logic mem_done,
  output logic busy
);
  import mpx_pkg::*;

  logic [15:0] accum_word;
  logic [15:0] port_or_high_word_reg;
  logic [15:0] dest_ptr_reg;
  logic [15:0] extra_seg_reg;
  logic [15:0] count_reg;
  logic [15:0] src_reg;
  logic [15:0] flags;
  logic [15:0] ctrl;
  logic [15:0] data_hold;
  logic done_sticky;
  mpx_state_e state;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic wr_fire;
  logic [7:0] port_imm;
  logic carry_flag;
  logic direction_flag;
  logic overflow_flag;

  assign carry_flag = flags[MPX_F_CARRY];
  assign direction_flag = flags[MPX_F_DIR];
  assign overflow_flag = flags[MPX_F_OVF];
  assign port_imm = ctrl[MPX_CTL_PORT_LO +: 8];

  // parity of the low byte: set on even count of ones
  function automatic logic even_par(input logic [7:0] v);
    even_par = ~^v;
  endfunction

  // decode whether a byte address names a register
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == MPX_OFF_CTRL) || (a == MPX_OFF_ACC) || (a == MPX_OFF_PHW) ||
      (a == MPX_OFF_DPTR) || (a == MPX_OFF_XSEG) || (a == MPX_OFF_CX) ||
      (a == MPX_OFF_SRC) || (a == MPX_OFF_FLAGS) || (a == MPX_OFF_STAT);
  endfunction

  // write address and data are taken independently
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MPX_RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? MPX_RESP_OK : MPX_RESP_ERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one cycle to data
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= MPX_RESP_OK;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? MPX_RESP_OK : MPX_RESP_ERR;
      case (s_axi_araddr)
        MPX_OFF_CTRL: s_axi_rdata <= {16'h0000, ctrl};
        MPX_OFF_ACC: s_axi_rdata <= {16'h0000, accum_word};
        MPX_OFF_PHW: s_axi_rdata <= {16'h0000, port_or_high_word_reg};
        MPX_OFF_DPTR: s_axi_rdata <= {16'h0000, dest_ptr_reg};
        MPX_OFF_XSEG: s_axi_rdata <= {16'h0000, extra_seg_reg};
        MPX_OFF_CX: s_axi_rdata <= {16'h0000, count_reg};
        MPX_OFF_SRC: s_axi_rdata <= {16'h0000, src_reg};
        MPX_OFF_FLAGS: s_axi_rdata <= {16'h0000, flags};
        MPX_OFF_STAT: s_axi_rdata <= {30'h0000_0000, done_sticky, busy};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // software writes to a register when idle; byte lanes 0 and 1 only
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
    input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  logic sw_wr;
  assign sw_wr = wr_fire && state == MPX_IDLE;
  logic [3:0] wstrb_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wstrb_q <= 4'h0;
    else if (s_axi_wvalid && !w_held)
      wstrb_q <= s_axi_wstrb;
  end

  // multiply and increment results
  logic signed [31:0] prod_w;
  logic signed [15:0] prod_b;
  logic [15:0] inc_res;
  logic [15:0] inc_src;
  logic is_word;
  assign is_word = ctrl[MPX_CTL_WORD];
  assign prod_w = $signed(src_reg) * $signed(accum_word);
  assign prod_b = $signed(src_reg[7:0]) * $signed(accum_word[7:0]);
  assign inc_src = src_reg;
  assign inc_res = inc_src + 16'h0001;
  logic [1:0] op;
  assign op = ctrl[MPX_CTL_OP_LO +: 2];
  logic start;
  assign start = sw_wr && aw_addr == MPX_OFF_CTRL && w_data[MPX_CTL_GO] && wstrb_q[0];
  logic [1:0] start_op;
  assign start_op = w_data[MPX_CTL_OP_LO +: 2];
  logic [15:0] step;
  assign step = is_word ? 16'h0002 : 16'h0001;

  // sequencer, operands, results and flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= MPX_IDLE;
      ctrl <= 16'h0000;
      accum_word <= 16'h0000;
      port_or_high_word_reg <= 16'h0000;
      dest_ptr_reg <= 16'h0000;
      extra_seg_reg <= 16'h0000;
      count_reg <= 16'h0000;
      src_reg <= 16'h0000;
      flags <= MPX_FLAGS_RST;
      data_hold <= 16'h0000;
      done_sticky <= 1'b0;
    end
    else
    begin
      case (state)
        MPX_IDLE:
        begin
          if (sw_wr)
          begin
            case (aw_addr)
              MPX_OFF_CTRL: ctrl <= merge(ctrl, w_data, wstrb_q) & ~16'h0001;
              MPX_OFF_ACC: accum_word <= merge(accum_word, w_data, wstrb_q);
              MPX_OFF_PHW: port_or_high_word_reg <= merge(port_or_high_word_reg, w_data, wstrb_q);
              MPX_OFF_DPTR: dest_ptr_reg <= merge(dest_ptr_reg, w_data, wstrb_q);
              MPX_OFF_XSEG: extra_seg_reg <= merge(extra_seg_reg, w_data, wstrb_q);
              MPX_OFF_CX: count_reg <= merge(count_reg, w_data, wstrb_q);
              MPX_OFF_SRC: src_reg <= merge(src_reg, w_data, wstrb_q);
              MPX_OFF_FLAGS: flags <= merge(flags, w_data, wstrb_q);
              MPX_OFF_STAT: done_sticky <= 1'b0;
              default: ;
            endcase
          end
          if (start)
          begin
            case (start_op)
              MPX_OP_MUL:
              begin
                done_sticky <= 1'b1;
                if (!w_data[MPX_CTL_WORD])
                begin
                  // (RQ1) byte product
                  accum_word <= prod_b;
                  // (RQ3) byte overflow check
                  flags[MPX_F_CARRY] <= prod_b[15:8] != {8{prod_b[7]}};
                  flags[MPX_F_OVF] <= prod_b[15:8] != {8{prod_b[7]}};
                end
                else
                begin
                  // (RQ2) word product split
                  accum_word <= prod_w[15:0];
                  port_or_high_word_reg <= prod_w[31:16];
                  // (RQ3) word overflow check
                  flags[MPX_F_CARRY] <= prod_w[31:16] != {16{prod_w[15]}};
                  flags[MPX_F_OVF] <= prod_w[31:16] != {16{prod_w[15]}};
                end
                // (RQ4) other flags left as they were
              end
              MPX_OP_INC:
              begin
                done_sticky <= 1'b1;
                // (RQ9) increment and flags, carry kept
                if (w_data[MPX_CTL_WORD])
                begin
                  src_reg <= inc_res;
                  flags[MPX_F_OVF] <= inc_src == 16'h7fff;
                  flags[MPX_F_SIGN] <= inc_res[15];
                  flags[MPX_F_ZERO] <= inc_res == 16'h0000;
                end
                else
                begin
                  src_reg[7:0] <= inc_res[7:0];
                  flags[MPX_F_OVF] <= inc_src[7:0] == 8'h7f;
                  flags[MPX_F_SIGN] <= inc_res[7];
                  flags[MPX_F_ZERO] <= inc_res[7:0] == 8'h00;
                end
                flags[MPX_F_AUX] <= inc_src[3:0] == 4'hf;
                flags[MPX_F_PAR] <= even_par(inc_res[7:0]);
              end
              MPX_OP_IN:
                state <= MPX_IOREQ;
              default:
              begin
                // (RQ13) zero count does nothing
                if (w_data[MPX_CTL_REP] && count_reg == 16'h0000)
                  done_sticky <= 1'b1;
                else
                  state <= MPX_IOREQ;
              end
            endcase
          end
        end
        MPX_IOREQ:
        begin
          if (io_done)
          begin
            if (op == MPX_OP_IN)
            begin
              // (RQ5) load by size; (RQ8) flags untouched
              if (is_word)
                accum_word <= io_rdata;
              else
                accum_word[7:0] <= io_rdata[7:0];
              done_sticky <= 1'b1;
              state <= MPX_IDLE;
            end
            else
            begin
              data_hold <= io_rdata;
              state <= MPX_MEMREQ;
            end
          end
        end
        MPX_MEMREQ:
          if (mem_done)
            state <= MPX_STEP;
        MPX_STEP:
        begin
          // (RQ11) pointer step by size and direction
          dest_ptr_reg <= direction_flag ? dest_ptr_reg - step : dest_ptr_reg + step;
          // (RQ12) (RQ13) repeat until count exhausted
          if (ctrl[MPX_CTL_REP])
          begin
            count_reg <= count_reg - 16'h0001;
            if (count_reg == 16'h0001)
            begin
              done_sticky <= 1'b1;
              state <= MPX_IDLE;
            end
            else
              state <= MPX_IOREQ;
          end
          else
          begin
            done_sticky <= 1'b1;
            state <= MPX_IDLE;
          end
        end
        default:
          state <= MPX_IDLE;
      endcase
    end
  end

  // bus interface requests
  assign busy = state != MPX_IDLE;
  assign io_req = state == MPX_IOREQ;
  // (RQ6) (RQ7) immediate reaches 0..255, register any 16-bit port
  assign io_port = (op == MPX_OP_IN && ctrl[MPX_CTL_IMM]) ? {8'h00, port_imm}
    : port_or_high_word_reg;
  assign io_word = is_word;
  // (RQ10) fixed extra segment, no override
  assign mem_req = state == MPX_MEMREQ;
  assign mem_seg = extra_seg_reg;
  assign mem_off = dest_ptr_reg;
  assign mem_word = is_word;
  assign mem_wdata = data_hold;

  // (RQ11) pointer step check
  a_ptr_step_dir: assert property (@(posedge aclk) disable iff (!aresetn) // (RQ11)
    state == MPX_STEP |=> dest_ptr_reg == ($past(direction_flag)
      ? $past(dest_ptr_reg) - $past(step) : $past(dest_ptr_reg) + $past(step)))
    else $error("pointer step wrong");
  a_mul_ovf_flag: assert property (@(posedge aclk) disable iff (!aresetn) // (RQ3)
    start && start_op == MPX_OP_MUL |=> carry_flag == overflow_flag && carry_flag ==
      (ctrl[MPX_CTL_WORD] ? port_or_high_word_reg != {16{accum_word[15]}}
      : accum_word[15:8] != {8{accum_word[7]}}))
    else $error("multiply carry and overflow differ");
  a_in_flags_kept: assert property (@(posedge aclk) disable iff (!aresetn) // (RQ8)
    state == MPX_IOREQ && op == MPX_OP_IN && !sw_wr |=> $stable(flags))
    else $error("port input changed flags");
  a_imm_port_range: assert property (@(posedge aclk) disable iff (!aresetn) // (RQ6)
    io_req && op == MPX_OP_IN && ctrl[MPX_CTL_IMM] |-> io_port[15:8] == 8'h00)
    else $error("immediate port out of range");
  a_seg_fixed: assert property (@(posedge aclk) disable iff (!aresetn) // (RQ10)
    mem_req && !mem_done |=> mem_req && $stable(mem_seg) && $stable(mem_off))
    else $error("block write address moved");
  a_inc_carry_kept: assert property (@(posedge aclk) disable iff (!aresetn) // (RQ9)
    start && start_op == MPX_OP_INC |=> carry_flag == $past(carry_flag))
    else $error("increment touched carry");
  a_rep_zero_none: assert property (@(posedge aclk) disable iff (!aresetn) // (RQ13)
    start && start_op == MPX_OP_BLK && w_data[MPX_CTL_REP] && count_reg == 16'h0000
      |=> state == MPX_IDLE)
    else $error("zero count started a transfer");
  a_rep_count_dec: assert property (@(posedge aclk) disable iff (!aresetn) // (RQ13)
    state == MPX_STEP && ctrl[MPX_CTL_REP] |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("count not decremented");
endmodule

// ### mpx_pkg.sv
// Purpose: shared constants for the multiply / port input / increment / block input unit
// Assumes: 16-bit core, AXI4-Lite register access with 32-bit data
// Notes: register offsets are byte addresses
package mpx_pkg;
  localparam logic [7:0] MPX_OFF_CTRL = 8'h00;
  localparam logic [7:0] MPX_OFF_ACC = 8'h04;
  localparam logic [7:0] MPX_OFF_PHW = 8'h08;
  localparam logic [7:0] MPX_OFF_DPTR = 8'h0c;
  localparam logic [7:0] MPX_OFF_XSEG = 8'h10;
  localparam logic [7:0] MPX_OFF_CX = 8'h14;
  localparam logic [7:0] MPX_OFF_SRC = 8'h18;
  localparam logic [7:0] MPX_OFF_FLAGS = 8'h1c;
  localparam logic [7:0] MPX_OFF_STAT = 8'h20;
  // ctrl fields
  localparam int MPX_CTL_GO = 0;
  localparam int MPX_CTL_WORD = 1;
  localparam int MPX_CTL_IMM = 2;
  localparam int MPX_CTL_REP = 3;
  localparam int MPX_CTL_OP_LO = 4;
  localparam int MPX_CTL_PORT_LO = 8;
  // op codes
  localparam logic [1:0] MPX_OP_MUL = 2'h0;
  localparam logic [1:0] MPX_OP_IN = 2'h1;
  localparam logic [1:0] MPX_OP_INC = 2'h2;
  localparam logic [1:0] MPX_OP_BLK = 2'h3;
  // flag bit positions in the flags word
  localparam int MPX_F_CARRY = 0;
  localparam int MPX_F_PAR = 2;
  localparam int MPX_F_AUX = 4;
  localparam int MPX_F_ZERO = 6;
  localparam int MPX_F_SIGN = 7;
  localparam int MPX_F_TRAP = 8;
  localparam int MPX_F_IF = 9;
  localparam int MPX_F_DIR = 10;
  localparam int MPX_F_OVF = 11;
  localparam logic [15:0] MPX_FLAGS_RST = 16'h0002;
  localparam logic [1:0] MPX_RESP_OK = 2'h0;
  localparam logic [1:0] MPX_RESP_ERR = 2'h2;
  typedef enum logic [3:0] {
    MPX_IDLE = 4'h1,
    MPX_IOREQ = 4'h2,
    MPX_MEMREQ = 4'h4,
    MPX_STEP = 4'h8
  } mpx_state_e;
endpackage

// ### tb_mpx_exec.sv
// Purpose: self-checking bench for mpx_exec driven over its register bus
// Assumes: mpx_bus_model answers io data as port xor c3a5
// Notes: each operation is a CTRL write followed by STAT polling
`timescale 1ns/10ps
module tb_mpx_exec;
  import mpx_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic io_req, io_word, io_done, mem_req, mem_word, mem_done, busy;
  logic [15:0] io_port, io_rdata, mem_seg, mem_off, mem_wdata;
  int num_errors = 0;
  int checks = 0;
  // free-running core clock
  always #5 aclk = ~aclk;
  mpx_exec mpx_exec_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .io_req, .io_port, .io_word, .io_done, .io_rdata, .mem_req,
    .mem_seg, .mem_off, .mem_word, .mem_wdata, .mem_done, .busy);
  mpx_bus_model mpx_bus_model_inst (.aclk, .aresetn, .io_req, .io_port, .io_word, .io_done,
    .io_rdata, .mem_req, .mem_seg, .mem_off, .mem_word, .mem_wdata, .mem_done);
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // a wait that ran out of cycles ends the run
  task automatic wait_fail();
    $display("wait limit reached at %0t", $time);
    num_errors++;
    report_and_stop();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 40) wait_fail();
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 40) wait_fail();
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, rd);
    chk_val(rd, e);
    chk_resp(resp, MPX_RESP_OK);
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] op, input logic w, input logic im,
    input logic rp, input logic [7:0] port);
    return {16'h0, port, 2'b00, op, rp, im, w, 1'b1};
  endfunction
  // start an operation and poll the busy bit with a bounded count
  task automatic run(input logic [31:0] c);
    int n;
    axi_wr(MPX_OFF_STAT, 32'h0);
    axi_wr(MPX_OFF_CTRL, c);
    for (n = 0; n < 60; n++)
    begin
      axi_rd(MPX_OFF_STAT, rd);
      if (rd[0] === 1'b0) break;
    end
    if (n == 60) wait_fail();
    chk_val({30'h0, rd[1], busy}, 32'h2);
  endtask
  task automatic mul_case(input logic w, input logic [15:0] acc, src, eax, edx, input logic big);
    axi_wr(MPX_OFF_FLAGS, 32'h0702);
    axi_wr(MPX_OFF_ACC, {16'h0, acc});
    axi_wr(MPX_OFF_PHW, 32'h5555);
    axi_wr(MPX_OFF_SRC, {16'h0, src});
    run(ctl(MPX_OP_MUL, w, 1'b0, 1'b0, 8'h00));
    expect_reg(MPX_OFF_ACC, {16'h0, eax});
    expect_reg(MPX_OFF_PHW, {16'h0, edx});
    expect_reg(MPX_OFF_FLAGS, {16'h0, 16'h0702 | (big ? 16'h0801 : 16'h0)});
    $display("test multiply done");
  endtask
  task automatic in_case(input logic w, im, input logic [7:0] pt, input logic [15:0] hw);
    logic [15:0] p;
    logic [15:0] d;
    p = im ? {8'h00, pt} : hw;
    d = p ^ 16'hc3a5;
    axi_wr(MPX_OFF_FLAGS, 32'h0fd7);
    axi_wr(MPX_OFF_ACC, 32'hbeef);
    axi_wr(MPX_OFF_PHW, {16'h0, hw});
    run(ctl(MPX_OP_IN, w, im, 1'b0, pt));
    chk_val({16'h0, mpx_bus_model_inst.last_port}, {16'h0, p});
    chk_val({31'h0, mpx_bus_model_inst.last_word}, {31'h0, w});
    expect_reg(MPX_OFF_ACC, w ? {16'h0, d} : {16'h0, 8'hbe, d[7:0]});
    expect_reg(MPX_OFF_FLAGS, 32'h0fd7);
    $display("test port input done");
  endtask
  task automatic inc_case(input logic w, input logic [15:0] fl, src, er, ef);
    axi_wr(MPX_OFF_FLAGS, {16'h0, fl});
    axi_wr(MPX_OFF_SRC, {16'h0, src});
    run(ctl(MPX_OP_INC, w, 1'b0, 1'b0, 8'h00));
    axi_rd(MPX_OFF_SRC, rd);
    chk_val(rd, {16'h0, er});
    expect_reg(MPX_OFF_FLAGS, {16'h0, ef});
    $display("test increment done");
  endtask
  task automatic blk_case(input logic w, rp, dn, input logic [15:0] cx, ptr, input int n,
    input logic [15:0] edi, ecx);
    int base;
    int k;
    logic [15:0] off;
    base = mpx_bus_model_inst.mem_cnt;
    off = ptr;
    axi_wr(MPX_OFF_FLAGS, dn ? 32'h0402 : 32'h0002);
    axi_wr(MPX_OFF_PHW, 32'h1234);
    axi_wr(MPX_OFF_XSEG, 32'h2000);
    axi_wr(MPX_OFF_DPTR, {16'h0, ptr});
    axi_wr(MPX_OFF_CX, {16'h0, cx});
    run(ctl(MPX_OP_BLK, w, 1'b0, rp, 8'h00));
    chk_val(32'(mpx_bus_model_inst.mem_cnt - base), 32'(n));
    for (k = 0; k < n; k++)
    begin
      chk_val({16'h0, mpx_bus_model_inst.log_off[(base + k) % 16]}, {16'h0, off});
      chk_val({16'h0, mpx_bus_model_inst.log_seg[(base + k) % 16]}, 32'h2000);
      chk_val({16'h0, mpx_bus_model_inst.log_data[(base + k) % 16]}, w ? 32'hd191 : 32'h91);
      off = dn ? off - (w ? 16'h2 : 16'h1) : off + (w ? 16'h2 : 16'h1);
    end
    expect_reg(MPX_OFF_DPTR, {16'h0, edi});
    expect_reg(MPX_OFF_CX, {16'h0, ecx});
    $display("test block input done");
  endtask
  // main sequence: reset, map checks, then each operation kind
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    expect_reg(MPX_OFF_FLAGS, {16'h0, MPX_FLAGS_RST});
    axi_wr(8'h40, 32'h1);
    chk_resp(resp, MPX_RESP_ERR);
    axi_rd(8'h40, rd);
    chk_resp(resp, MPX_RESP_ERR);
    chk_val(rd, 32'h0);
    $display("test reset and map done");
    mul_case(1'b0, 16'h77fd, 16'h0005, 16'hfff1, 16'h5555, 1'b0);
    mul_case(1'b0, 16'h0080, 16'h0080, 16'h4000, 16'h5555, 1'b1);
    mul_case(1'b1, 16'h1234, 16'h0100, 16'h3400, 16'h0012, 1'b1);
    mul_case(1'b1, 16'hffff, 16'h0005, 16'hfffb, 16'hffff, 1'b0);
    mul_case(1'b1, 16'h8000, 16'hffff, 16'h8000, 16'h0000, 1'b1);
    in_case(1'b0, 1'b1, 8'hff, 16'h1234);
    in_case(1'b1, 1'b1, 8'h00, 16'h1234);
    in_case(1'b0, 1'b0, 8'h00, 16'hffff);
    in_case(1'b1, 1'b0, 8'h12, 16'h8001);
    inc_case(1'b0, 16'h0703, 16'h12ff, 16'h1200, 16'h0757);
    inc_case(1'b0, 16'h0703, 16'h007f, 16'h0080, 16'h0f93);
    inc_case(1'b1, 16'h0703, 16'h7fff, 16'h8000, 16'h0f97);
    inc_case(1'b1, 16'h0703, 16'hffff, 16'h0000, 16'h0757);
    inc_case(1'b1, 16'h0fd7, 16'h0100, 16'h0101, 16'h0703);
    blk_case(1'b0, 1'b1, 1'b0, 16'd3, 16'h0010, 3, 16'h0013, 16'h0000);
    blk_case(1'b1, 1'b1, 1'b1, 16'd2, 16'h0100, 2, 16'h00fc, 16'h0000);
    blk_case(1'b0, 1'b0, 1'b1, 16'd5, 16'h0000, 1, 16'hffff, 16'h0005);
    blk_case(1'b1, 1'b1, 1'b0, 16'd0, 16'h0040, 0, 16'h0040, 16'h0000);
    blk_case(1'b1, 1'b0, 1'b0, 16'd7, 16'hfffe, 1, 16'h0000, 16'h0007);
    report_and_stop();
  end
endmodule
